// ===== src/usart_pkg.sv
package usart_pkg;
  // =====================================================
  // register indices (byte address = 4 * index)
  localparam logic [3:0] IDX_RXDL = 4'h0;
  localparam logic [3:0] IDX_RXDH = 4'h1;
  localparam logic [3:0] IDX_TXDL = 4'h2;
  localparam logic [3:0] IDX_TXDH = 4'h3;
  localparam logic [3:0] IDX_STAT = 4'h4;
  localparam logic [3:0] IDX_CTLA = 4'h5;
  localparam logic [3:0] IDX_CTLB = 4'h6;
  localparam logic [3:0] IDX_CTLC = 4'h7;
  localparam logic [3:0] IDX_BAUD = 4'h8;
  localparam logic [3:0] IDX_CTLD = 4'hA;
  localparam logic [3:0] IDX_DBGC = 4'hB;
  localparam logic [3:0] IDX_EVCT = 4'hC;
  localparam logic [3:0] IDX_TXPL = 4'hD;
  localparam logic [3:0] IDX_RXPL = 4'hE;
  // =====================================================
  // field positions
  localparam int CA_RX_IE = 7;
  localparam int CA_TXD_IE = 6;
  localparam int CA_TXE_IE = 5;
  localparam int CA_RXS_IE = 4;
  localparam int CA_SYN_IE = 2;
  localparam int CB_SFDEN = 4;
  localparam int CB_MPM = 0;
  localparam int ST_TXD = 6;
  localparam int ST_RXS = 4;
  localparam int ST_ISF = 3;
  localparam int EV_IREN = 0;
  // =====================================================
  // field encodings
  localparam logic [2:0] CHS_8BIT = 3'h3;
  localparam logic [2:0] CHS_9LF = 3'h6;
  localparam logic [2:0] CHS_9HF = 3'h7;
  localparam logic [2:0] CHS_BASE = 3'h5;
  localparam logic [1:0] CM_SYNC = 2'h1;
  localparam logic [1:0] CM_MSPI = 2'h3;
  localparam logic [1:0] PM_EVEN = 2'h2;
  localparam logic [1:0] PM_ODD = 2'h3;
  // =====================================================
  // receive buffer entry: {frame err, parity err, data[8:0]}
  localparam int ENT_W = 11;
  localparam int E_FRM = 10;
  localparam int E_PAR = 9;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] CNT_FULL = 2'h2;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_NONE = 2'h0;
  // =====================================================
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage : usart_pkg

// ===== src/rx_frame_buffer.sv
`timescale 1ns/1ns
module rx_frame_buffer
  import usart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [ENT_W-1:0] push_data,
  input wire logic pop,
  output logic [ENT_W-1:0] head,
  output logic [1:0] count
);
  // =====================================================
  // two-entry store, oldest at rd_ptr
  logic [ENT_W-1:0] mem [BUF_DEPTH];
  logic rd_ptr;
  logic wr_ptr;
  logic do_push;
  logic do_pop;
  logic [1:0] next_count;

  // push accepted when room, or when a pop frees a slot
  assign do_pop = pop && (count != CNT_NONE);
  assign do_push = push && ((count != CNT_FULL) || do_pop);
  assign next_count = 2'(count + {1'b0, do_push} - {1'b0, do_pop});
  // oldest frame, zero when empty
  assign head = (count != CNT_NONE) ? mem[rd_ptr] : ENT_W'(0);

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= CNT_NONE;
    end else begin
      rd_ptr <= rd_ptr ^ do_pop;
      wr_ptr <= wr_ptr ^ do_push;
      count <= next_count;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_count_bound: assert property (count <= CNT_FULL) // RL14
    else $error("receive buffer count above two");
  a_fifo_order: assert property (count == CNT_FULL && do_pop && !do_push |=> // RL14
      head == $past(mem[~rd_ptr]))
    else $error("second frame not presented after pop");
endmodule : rx_frame_buffer

// ===== src/usart_mp_rx.sv
`timescale 1ns/1ns
// Overview of operation
// RL1 - writing one to multiproc_mode_en enables address filtering, zero disables it
// RL2 - with five to eight data bits the first stop bit gives frame type
// RL3 - with nine data bits the ninth data bit gives frame type
// RL4 - frame type one means address frame, zero means data frame
// RL5 - senders using five to eight bits must send two stop bits
// RL6 - in multiprocessor mode data frames are dropped, address frames kept
// RL7 - addressed client clears mode for data, sets it again afterwards
// RL8 - in host synchronous or host SPI mode emit the transfer clock event
// RL9 - infrared event input is taken as a synchronous pulse source
// RL10 - receive vector: unread data, start detect or sync error, each enabled
// RL11 - empty vector raised while transmit buffer empty and its enable set
// RL12 - done vector raised when frame fully sent, buffer empty, enable set (TX_SHIFT_DONE alone sets the flag, TX_BUF_EMPTY not checked)
// RL13 - request stands while flag and enable are set, until flag clears
// RL14 - two frames buffered; registers always show the oldest one
// RL15 - nine-bit low-first: high register read advances; otherwise low register
// RL16 - software reads the non-advancing register first, then the advancing one
// RL17 - low receive register gives low eight data bits, read-only, reset zero
// RL18 - receive complete flag follows unread data, in status and high register
// RL19 - overrun: buffer full, frame pending, new start; cleared by data read
// RL20 - frame error set when first stop bit is zero, clear when one
// RL21 - high register bits: 7 complete, 6 overrun, 2 frame, 1 parity, 0 data
// RL22 - parity error set when checking enabled and parity mismatches
// RL23 - nine-bit frames carry the top data bit in bit zero
module usart_mp_rx
  import usart_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic RX_START,
  input wire logic RX_FRAME_VALID,
  input wire logic [8:0] RX_FRAME_DATA,
  input wire logic RX_STOP1,
  input wire logic RX_PARITY,
  input wire logic TX_BUF_EMPTY,
  input wire logic TX_SHIFT_DONE,
  input wire logic SYNC_ERR,
  input wire logic XFER_CLK_IN,
  input wire logic IRDA_EVENT_IN,
  output logic RX_COMPLETE_VECTOR,
  output logic TX_EMPTY_VECTOR,
  output logic TX_DONE_VECTOR,
  output logic XFER_CLOCK_EVT,
  output logic IR_RX_SRC,
  output logic TX_LOAD,
  output logic [8:0] TX_DATA
);
  // =====================================================
  // parity of the data bits that the character size uses
  function automatic logic data_parity(input logic [8:0] d, input logic [2:0] chs);
    logic [8:0] mask;
    mask = 9'h0FF;
    if (chs == CHS_9LF || chs == CHS_9HF) begin
      mask = 9'h1FF;
    end else if (chs <= CHS_8BIT) begin
      mask = 9'((9'h1 << (4'(chs) + 4'(CHS_BASE))) - 9'h1);
    end
    return ^(d & mask);
  endfunction : data_parity

  // =====================================================
  // bus slave: address phase capture
  logic dp_valid;
  logic dp_write;
  logic [3:0] dp_idx;
  logic [31:0] rdata;
  logic acc;
  logic addr_ok;
  logic [3:0] idx;
  logic rd_now;
  logic wr_now;

  // accepted transfer and its register index
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign idx = HADDR[5:2];
  assign addr_ok = (HADDR[31:6] == 26'h0);
  assign rd_now = acc && !HWRITE && addr_ok;
  assign wr_now = dp_valid && dp_write;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata;

  // data phase state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx <= IDX_RXDL;
    end else begin
      dp_valid <= acc && addr_ok;
      dp_write <= HWRITE;
      dp_idx <= idx;
    end
  end

  // =====================================================
  // software registers
  logic [7:0] ctla;
  logic [7:0] ctlb;
  logic [7:0] ctlc;
  logic [7:0] ctld;
  logic [7:0] dbgc;
  logic [7:0] evct;
  logic [7:0] txpl;
  logic [7:0] rxpl;
  logic [15:0] baud;
  logic [7:0] tx_lo;
  logic tx_hi;
  logic [7:0] wb;

  // write strobes per register
  assign wb = HWDATA[7:0];
  wire we_ctla = wr_now && (dp_idx == IDX_CTLA);
  wire we_ctlb = wr_now && (dp_idx == IDX_CTLB);
  wire we_ctlc = wr_now && (dp_idx == IDX_CTLC);
  wire we_ctld = wr_now && (dp_idx == IDX_CTLD);
  wire we_dbgc = wr_now && (dp_idx == IDX_DBGC);
  wire we_evct = wr_now && (dp_idx == IDX_EVCT);
  wire we_txpl = wr_now && (dp_idx == IDX_TXPL);
  wire we_rxpl = wr_now && (dp_idx == IDX_RXPL);
  wire we_baud = wr_now && (dp_idx == IDX_BAUD);
  wire we_txlo = wr_now && (dp_idx == IDX_TXDL);
  wire we_txhi = wr_now && (dp_idx == IDX_TXDH);
  wire we_stat = wr_now && (dp_idx == IDX_STAT);

  // mode decode
  wire [2:0] chs = ctlc[2:0];
  wire [1:0] cmode = ctlc[7:6];
  wire [1:0] pmode = ctlc[5:4];
  wire nine = (chs == CHS_9LF) || (chs == CHS_9HF);
  wire nine_lf = (chs == CHS_9LF);
  wire spi_host = (cmode == CM_MSPI);
  wire host_sync = (cmode == CM_SYNC) || spi_host;
  wire mp_mode = ctlb[CB_MPM];
  wire par_en = (pmode == PM_EVEN) || (pmode == PM_ODD);

  // control register storage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctla <= REG_RST;
      ctlb <= REG_RST;
      ctlc <= REG_RST;
      ctld <= REG_RST;
      dbgc <= REG_RST;
      evct <= REG_RST;
      txpl <= REG_RST;
      rxpl <= REG_RST;
      baud <= BAUD_RST;
    end else begin
      if (we_ctla) ctla <= wb;
      if (we_ctlb) ctlb <= wb; // RL1
      if (we_ctlc) ctlc <= wb;
      if (we_ctld) ctld <= wb;
      if (we_dbgc) dbgc <= wb;
      if (we_evct) evct <= wb;
      if (we_txpl) txpl <= wb;
      if (we_rxpl) rxpl <= {1'b0, wb[6:0]};
      if (we_baud) baud <= HWDATA[15:0];
    end
  end

  // =====================================================
  // transmit data holding and load strobe
  wire tx_shift_wr = nine_lf ? we_txhi : we_txlo;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_lo <= REG_RST;
      tx_hi <= 1'b0;
      TX_LOAD <= 1'b0;
      TX_DATA <= 9'h000;
    end else begin
      if (we_txlo) tx_lo <= wb;
      if (we_txhi) tx_hi <= wb[0];
      TX_LOAD <= tx_shift_wr;
      if (tx_shift_wr) TX_DATA <= {we_txhi ? wb[0] : tx_hi, we_txlo ? wb : tx_lo};
    end
  end

  // =====================================================
  // frame intake and filtering
  logic [1:0] cnt;
  logic [ENT_W-1:0] head;
  logic pend_valid;
  logic [ENT_W-1:0] pend_data;
  logic ovf;
  logic fr_type;
  logic keep;
  logic frm_bit;
  logic par_bit;
  logic [ENT_W-1:0] entry;
  logic pop;
  logic pop_ok;
  logic full;
  logic move_pend;
  logic push;
  logic to_pend;
  logic [ENT_W-1:0] push_data;

  // frame type from stop slot or ninth bit
  assign fr_type = nine ? RX_FRAME_DATA[8] : RX_STOP1; // RL2 RL3
  // address frames pass in multiprocessor mode
  assign keep = RX_FRAME_VALID && (!mp_mode || fr_type); // RL4 RL6
  assign frm_bit = !spi_host && !RX_STOP1; // RL20
  assign par_bit = !spi_host && par_en && // RL22
    (RX_PARITY != (data_parity(RX_FRAME_DATA, chs) ^ (pmode == PM_ODD)));
  assign entry = {frm_bit, par_bit, nine ? RX_FRAME_DATA[8] : 1'b0, // RL23
    RX_FRAME_DATA[7:0]};

  // read of the advancing register pops the oldest frame
  assign pop = rd_now && (idx == (nine_lf ? IDX_RXDH : IDX_RXDL)); // RL15
  assign pop_ok = pop && (cnt != CNT_NONE);
  assign full = (cnt == CNT_FULL);
  // frame parked in the shift stage moves in once a slot frees
  assign move_pend = pend_valid && pop_ok;
  assign push = move_pend || (keep && !pend_valid && (!full || pop_ok));
  assign push_data = move_pend ? pend_data : entry;
  assign to_pend = keep && (move_pend || (!pend_valid && full && !pop_ok));

  // two-frame receive store
  rx_frame_buffer u_buf (
    .clk(CLK),
    .rst_n(RST_N),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .head(head),
    .count(cnt)
  );

  // shift-stage holding slot
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_valid <= 1'b0;
      pend_data <= ENT_W'(0);
    end else begin
      pend_valid <= to_pend || (pend_valid && !move_pend);
      if (to_pend) pend_data <= entry;
    end
  end

  // overrun flag, a new set beats the read clear
  wire ovf_set = RX_START && full && pend_valid && !spi_host; // RL19
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf <= 1'b0;
    end else begin
      ovf <= ovf_set || (ovf && !pop_ok); // RL19
    end
  end

  // =====================================================
  // status flags
  logic rxd_flag;
  logic txd_flag;
  logic rxs_flag;
  logic isf_flag;
  logic txe_flag;

  assign rxd_flag = (cnt != CNT_NONE); // RL18
  assign txe_flag = TX_BUF_EMPTY;

  // write-one-to-clear flags, set wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      txd_flag <= 1'b0;
      rxs_flag <= 1'b0;
      isf_flag <= 1'b0;
    end else begin
      txd_flag <= TX_SHIFT_DONE || (txd_flag && !(we_stat && wb[ST_TXD]));
      rxs_flag <= (RX_START && ctlb[CB_SFDEN] && !spi_host) ||
        (rxs_flag && !(we_stat && wb[ST_RXS]));
      isf_flag <= SYNC_ERR || (isf_flag && !(we_stat && wb[ST_ISF]));
    end
  end

  // =====================================================
  // interrupt vectors from flag and enable
  assign RX_COMPLETE_VECTOR = (rxd_flag && ctla[CA_RX_IE]) || // RL10 RL13
    (rxs_flag && ctla[CA_RXS_IE]) || (isf_flag && ctla[CA_SYN_IE]);
  assign TX_EMPTY_VECTOR = txe_flag && ctla[CA_TXE_IE]; // RL11 RL13
  assign TX_DONE_VECTOR = txd_flag && ctla[CA_TXD_IE]; // RL12 RL13

  // =====================================================
  // event generator and event user
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      XFER_CLOCK_EVT <= 1'b0;
      IR_RX_SRC <= 1'b0;
    end else begin
      XFER_CLOCK_EVT <= host_sync && XFER_CLK_IN; // RL8
      IR_RX_SRC <= evct[EV_IREN] && IRDA_EVENT_IN; // RL9
    end
  end

  // =====================================================
  // read data selection
  logic [7:0] rxdh;
  logic [7:0] stat;
  logic [31:0] rd_mux;

  // high data register layout
  assign rxdh = {rxd_flag, ovf, 3'h0, head[E_FRM], head[E_PAR], head[8]}; // RL21
  assign stat = {rxd_flag, txd_flag, txe_flag, rxs_flag, isf_flag, 3'h0}; // RL18
  assign rd_mux =
    (idx == IDX_RXDL) ? {24'h0, head[7:0]} : // RL14 RL17
    (idx == IDX_RXDH) ? {24'h0, rxdh} : // RL14
    (idx == IDX_TXDL) ? {24'h0, tx_lo} :
    (idx == IDX_TXDH) ? {31'h0, tx_hi} :
    (idx == IDX_STAT) ? {24'h0, stat} :
    (idx == IDX_CTLA) ? {24'h0, ctla} :
    (idx == IDX_CTLB) ? {24'h0, ctlb} :
    (idx == IDX_CTLC) ? {24'h0, ctlc} :
    (idx == IDX_BAUD) ? {16'h0, baud} :
    (idx == IDX_CTLD) ? {24'h0, ctld} :
    (idx == IDX_DBGC) ? {24'h0, dbgc} :
    (idx == IDX_EVCT) ? {24'h0, evct} :
    (idx == IDX_TXPL) ? {24'h0, txpl} :
    (idx == IDX_RXPL) ? {24'h0, rxpl} : WORD_RST;

  // read word captured in the address phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata <= WORD_RST;
    end else if (acc && !HWRITE) begin
      rdata <= addr_ok ? rd_mux : WORD_RST;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_mp_data_drop: assert property (mp_mode && RX_FRAME_VALID && !fr_type && // RL6
      !pend_valid && !pop_ok |=> cnt == $past(cnt))
    else $error("data frame accepted in multiprocessor mode");
  a_mp_addr_take: assert property (mp_mode && RX_FRAME_VALID && fr_type && // RL4
      cnt == CNT_NONE |=> cnt == CNT_ONE)
    else $error("address frame not buffered");
  a_rxd_clear: assert property (cnt == CNT_ONE && pop_ok && !push |=> // RL18
      !rxd_flag && !RX_COMPLETE_VECTOR)
    else $error("complete flag stays after last read");
  a_ovf_set: assert property (ovf_set |=> ovf) // RL19
    else $error("overrun not flagged");
  a_ovf_clear: assert property (ovf && pop_ok && !ovf_set |=> !ovf) // RL19
    else $error("overrun not cleared by data read");
  a_low_no_pop: assert property (nine_lf && rd_now && idx == IDX_RXDL && // RL15
      !push |=> cnt == $past(cnt))
    else $error("low read advanced nine-bit low-first buffer");
  a_frm_cap: assert property (cnt == CNT_NONE && keep && !pend_valid && // RL20
      !spi_host |=> head[E_FRM] == !$past(RX_STOP1))
    else $error("frame error bit wrong");
  a_done_hold: assert property (txd_flag && ctla[CA_TXD_IE] && !we_stat && // RL13
      !we_ctla |=> TX_DONE_VECTOR [*1])
    else $error("done request dropped while flag set");
  a_ir_event: assert property (evct[EV_IREN] && IRDA_EVENT_IN |=> IR_RX_SRC) // RL9
    else $error("infrared event not passed");
  a_xfer_evt: assert property (host_sync && XFER_CLK_IN |=> XFER_CLOCK_EVT) // RL8
    else $error("transfer clock event missing");

  c_pend_move: cover property (move_pend);
  c_overrun: cover property (ovf_set);
  c_mp_addr: cover property (mp_mode && keep);
endmodule : usart_mp_rx

// ===== verif/serial_node.sv
`timescale 1ns/1ns
module serial_node (
  input wire logic clk,
  output logic start,
  output logic valid,
  output logic [8:0] data,
  output logic stop1,
  output logic parity
);
  // ====================
  // line idle: no frame in flight
  initial begin
    start = 1'b0;
    valid = 1'b0;
    data = 9'h0AA;
    stop1 = 1'b1;
    parity = 1'b0;
  end

  // ====================
  // one frame: start pulse, then the character after gap cycles
  task automatic send(input logic [8:0] d, input logic ftype, input logic nine,
                      input logic pflip, input int gap);
    logic [8:0] v;
    v = nine ? {ftype, d[7:0]} : d;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (gap) @(posedge clk);
    valid <= 1'b1;
    data <= v;
    stop1 <= nine ? 1'b1 : ftype;
    parity <= ^v[7:0] ^ pflip;
    @(posedge clk);
    valid <= 1'b0;
    // released lines never keep the last character
    data <= ~v;
    stop1 <= ~stop1;
    parity <= ~parity;
  endtask : send
endmodule : serial_node

// ===== verif/tb.sv
`timescale 1ns/1ns
module tb;
  import usart_pkg::*;
  // ====================
  // bench signals
  logic CLK, RST_N, HSEL, HWRITE, TX_BUF_EMPTY, TX_SHIFT_DONE, SYNC_ERR, TXL;
  logic XFER_CLK_IN, IRDA_EVENT_IN, HREADYOUT, HRESP, RX_START, RX_FRAME_VALID;
  logic RX_STOP1, RX_PARITY, RXD_V, TXE_V, TXD_V, XFER_EVT, IR_SRC, rd_dphase;
  logic [31:0] HADDR, HWDATA, HRDATA, rng, v, pv;
  logic [1:0] HTRANS;
  logic [8:0] RX_FRAME_DATA, TXW;
  logic [8:0] d [4];
  logic [31:0] exp_q [$];
  int fail_count, n_tests;

  usart_mp_rx i_usart_mp_rx (
    .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_START(RX_START),
    .RX_FRAME_VALID(RX_FRAME_VALID), .RX_FRAME_DATA(RX_FRAME_DATA), .RX_STOP1(RX_STOP1),
    .RX_PARITY(RX_PARITY), .TX_BUF_EMPTY(TX_BUF_EMPTY), .TX_SHIFT_DONE(TX_SHIFT_DONE),
    .SYNC_ERR(SYNC_ERR), .XFER_CLK_IN(XFER_CLK_IN), .IRDA_EVENT_IN(IRDA_EVENT_IN),
    .RX_COMPLETE_VECTOR(RXD_V), .TX_EMPTY_VECTOR(TXE_V), .TX_DONE_VECTOR(TXD_V),
    .XFER_CLOCK_EVT(XFER_EVT), .IR_RX_SRC(IR_SRC), .TX_LOAD(TXL), .TX_DATA(TXW)
  );
  serial_node node (.clk(CLK), .start(RX_START), .valid(RX_FRAME_VALID),
    .data(RX_FRAME_DATA), .stop1(RX_STOP1), .parity(RX_PARITY));

  // 4 ns clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // ====================
  // helpers
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  function automatic logic [31:0] ad(input logic [3:0] i);
    return {26'h0, i, 2'b00};
  endfunction : ad

  // high data register image of one buffered frame
  function automatic logic [31:0] hi(input logic ov, input logic [8:0] dd, input logic fe,
                                     input logic pe);
    return {24'h0, 1'b1, ov, 3'b000, fe, pe, dd[8]};
  endfunction : hi

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // waits for hready at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      complete_run();
    end
  endtask : wait_ready

  // single word transfer; a read notes its expected data
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] dat);
    @(posedge CLK);
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    if (!wr) exp_q.push_back(dat);
    wait_ready();
    HTRANS <= 2'h0;
    if (wr) HWDATA <= dat;
    wait_ready();
  endtask : bus

  // reads one frame: non-advancing register first
  task automatic pair(input logic lf, input logic [8:0] dd, input logic fe, pe, ov);
    if (lf) begin
      bus(0, ad(IDX_RXDL), {24'h0, dd[7:0]});
      bus(0, ad(IDX_RXDL), {24'h0, dd[7:0]});
      bus(0, ad(IDX_RXDH), hi(ov, dd, fe, pe));
    end else begin
      bus(0, ad(IDX_RXDH), hi(ov, dd, fe, pe));
      bus(0, ad(IDX_RXDH), hi(ov, dd, fe, pe));
      bus(0, ad(IDX_RXDL), {24'h0, dd[7:0]});
    end
  endtask : pair

  task automatic fill();
    for (int k = 0; k < 4; k++) d[k] = {1'b0, 8'(rnd())};
  endtask : fill

  // vector outputs once settled: {receive, empty, done}
  task automatic vchk(input logic [2:0] e);
    @(negedge CLK);
    check("vectors", {29'h0, e}, {29'h0, RXD_V, TXE_V, TXD_V});
  endtask : vchk

  // transmit strobe and word once a write has landed: {load, word}
  task automatic tchk(input logic [9:0] e);
    @(negedge CLK);
    check("tx_load_word", {22'h0, e}, {22'h0, TXL, TXW});
  endtask : tchk

  task automatic pulse(input int w);
    @(posedge CLK);
    if (w == 0) TX_SHIFT_DONE <= 1'b1;
    else SYNC_ERR <= 1'b1;
    @(posedge CLK);
    TX_SHIFT_DONE <= 1'b0;
    SYNC_ERR <= 1'b0;
  endtask : pulse

  // ====================
  // read monitor: oldest note against each read data phase
  always @(posedge CLK) begin
    if (rd_dphase === 1'b1 && HREADYOUT === 1'b1) begin
      check("HRDATA", exp_q.pop_front(), HRDATA);
      check("HRESP", WORD_RST, {31'h0, HRESP});
    end
    rd_dphase <= HSEL & HTRANS[1] & ~HWRITE & HREADYOUT;
  end

  // ====================
  // main sequence
  initial begin
    rng = 32'h0000_0048;
    fail_count = 0;
    n_tests = 0;
    rd_dphase = 1'b0;
    RST_N = 1'b0;
    HSEL = 1'b1;
    HTRANS = 2'h0;
    HADDR = WORD_RST;
    HWRITE = 1'b0;
    HWDATA = WORD_RST;
    TX_BUF_EMPTY = 1'b0;
    TX_SHIFT_DONE = 1'b0;
    SYNC_ERR = 1'b0;
    XFER_CLK_IN = 1'b0;
    IRDA_EVENT_IN = 1'b0;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    // reset values, read-only and unmapped places
    for (int i = 0; i < 16; i++) bus(0, ad(i[3:0]), WORD_RST);
    bus(1, 32'h0000_0054, 32'h0000_00FF);
    bus(0, ad(IDX_CTLA), WORD_RST);
    bus(1, ad(IDX_RXDL), 32'h0000_00FF);
    bus(0, ad(IDX_RXDL), WORD_RST);
    bus(1, ad(IDX_BAUD), 32'h0000_BEEF);
    bus(0, ad(IDX_BAUD), 32'h0000_BEEF);
    bus(1, ad(IDX_RXPL), 32'h0000_00FF);
    bus(0, ad(IDX_RXPL), 32'h0000_007F);
    // two buffered frames, oldest first, frame error on the second
    fill();
    bus(1, ad(IDX_CTLC), {24'h0, 5'h00, CHS_8BIT});
    node.send(d[0], 1'b1, 1'b0, 1'b0, 0);
    node.send(d[1], 1'b0, 1'b0, 1'b0, 5);
    pair(0, d[0], 0, 0, 0);
    pair(0, d[1], 1, 0, 0);
    bus(0, ad(IDX_RXDH), WORD_RST);
    // overrun: two buffered, one pending, then a new start
    fill();
    for (int k = 0; k < 4; k++) node.send(d[k], 1'b1, 1'b0, 1'b0, 0);
    pair(0, d[0], 0, 0, 1);
    pair(0, d[1], 0, 0, 0);
    pair(0, d[2], 0, 0, 0);
    bus(0, ad(IDX_RXDH), WORD_RST);
    // parity in both senses, good and bad
    for (int k = 0; k < 4; k++) begin
      fill();
      bus(1, ad(IDX_CTLC), {24'h0, 2'b00, k[1] ? PM_ODD : PM_EVEN, 1'b0, CHS_8BIT});
      node.send(d[0], 1'b1, 1'b0, k[0] ^ k[1], 0);
      pair(0, d[0], 0, k[0], 0);
    end
    // address filtering with eight-bit characters
    fill();
    bus(1, ad(IDX_CTLC), {24'h0, 5'h00, CHS_8BIT});
    bus(1, ad(IDX_CTLB), 32'h0000_0001);
    node.send(d[0], 1'b0, 1'b0, 1'b0, 0);
    node.send(d[1], 1'b1, 1'b0, 1'b0, 0);
    node.send(d[2], 1'b0, 1'b0, 1'b0, 3);
    pair(0, d[1], 0, 0, 0);
    bus(0, ad(IDX_RXDH), WORD_RST);
    bus(1, ad(IDX_CTLB), WORD_RST);
    node.send(d[3], 1'b0, 1'b0, 1'b0, 0);
    pair(0, d[3], 1, 0, 0);
    bus(1, ad(IDX_CTLB), 32'h0000_0001);
    node.send(d[0], 1'b0, 1'b0, 1'b0, 0);
    bus(0, ad(IDX_RXDH), WORD_RST);
    // nine-bit filtering, then nine-bit low-first without filtering
    bus(1, ad(IDX_CTLC), {24'h0, 5'h00, CHS_9HF});
    node.send(d[0], 1'b0, 1'b1, 1'b0, 0);
    node.send(d[1], 1'b1, 1'b1, 1'b0, 0);
    pair(0, {1'b1, d[1][7:0]}, 0, 0, 0);
    bus(0, ad(IDX_RXDH), WORD_RST);
    bus(1, ad(IDX_CTLB), WORD_RST);
    bus(1, ad(IDX_CTLC), {24'h0, 5'h00, CHS_9LF});
    node.send(d[2], 1'b1, 1'b1, 1'b0, 0);
    node.send(d[3], 1'b0, 1'b1, 1'b0, 0);
    pair(1, {1'b1, d[2][7:0]}, 0, 0, 0);
    pair(1, {1'b0, d[3][7:0]}, 0, 0, 0);
    bus(0, ad(IDX_RXDH), WORD_RST);
    // vectors: raise and clear each source, hold the done request, mask the receive request
    bus(1, ad(IDX_CTLC), {24'h0, 5'h00, CHS_8BIT});
    bus(1, ad(IDX_CTLA), 32'h0000_00F4);
    bus(1, ad(IDX_CTLB), 32'h0000_0010);
    vchk(3'b000);
    @(posedge CLK);
    TX_BUF_EMPTY <= 1'b1;
    vchk(3'b010);
    bus(0, ad(IDX_STAT), 32'h0000_0020);
    TX_BUF_EMPTY <= 1'b0;
    pulse(0);
    vchk(3'b001);
    repeat (5) @(posedge CLK);
    vchk(3'b001);
    bus(0, ad(IDX_STAT), 32'h0000_0040);
    bus(1, ad(IDX_STAT), 32'h0000_0040);
    vchk(3'b000);
    pulse(1);
    vchk(3'b100);
    bus(0, ad(IDX_STAT), 32'h0000_0008);
    bus(1, ad(IDX_STAT), 32'h0000_0008);
    vchk(3'b000);
    node.send(d[0], 1'b1, 1'b0, 1'b0, 0);
    bus(0, ad(IDX_STAT), 32'h0000_0090);
    bus(1, ad(IDX_STAT), 32'h0000_0010);
    vchk(3'b100);
    bus(1, ad(IDX_CTLA), 32'h0000_0074);
    vchk(3'b000);
    bus(1, ad(IDX_CTLA), 32'h0000_00F4);
    vchk(3'b100);
    bus(0, ad(IDX_RXDL), {24'h0, d[0][7:0]});
    vchk(3'b000);
    // transmit word and load strobe in both shifting orders
    bus(1, ad(IDX_TXDH), 32'h0000_0001);
    bus(1, ad(IDX_TXDL), 32'h0000_005A);
    tchk(10'h35A);
    bus(1, ad(IDX_CTLC), {24'h0, 5'h00, CHS_9LF});
    bus(1, ad(IDX_TXDL), 32'h0000_00A5);
    tchk(10'h15A);
    bus(0, ad(IDX_TXDL), 32'h0000_00A5);
    bus(1, ad(IDX_TXDH), WORD_RST);
    tchk(10'h2A5);
    // event outputs in every mode, infrared input on and off
    for (int k = 0; k < 8; k++) begin
      bus(1, ad(IDX_CTLC), {24'h0, k[1:0], 6'h03});
      bus(1, ad(IDX_EVCT), {31'h0, k[2]});
      for (int j = 0; j < 5; j++) begin
        @(posedge CLK);
        pv = v;
        v = rnd();
        XFER_CLK_IN <= v[0];
        IRDA_EVENT_IN <= v[1];
        @(negedge CLK);
        if (j > 0) check("xfer_clock", {31'h0, k[0] & pv[0]}, {31'h0, XFER_EVT});
        if (j > 0) check("ir_source", {31'h0, k[2] & pv[1]}, {31'h0, IR_SRC});
      end
    end
    complete_run();
  end
endmodule : tb
